// [include/charger_regs_pkg.sv]
// Register map, field layout, reset values and carrier types for the charger boost and status slice.
package charger_regs_pkg;

    // Register addresses on the serial register port.
    localparam logic [7:0] ADDR_BOOST_CTRL = 8'h1e;
    localparam logic [7:0] ADDR_USB_DET = 8'h1f;
    localparam logic [7:0] ADDR_LOOP_MON = 8'h20;
    localparam logic [7:0] ADDR_PATH_MON = 8'h21;

    // Boost converter control fields.
    localparam int BOOST_CONNECT_BIT = 6;
    localparam int BOOST_ENABLE_BIT = 5;
    localparam int BOOST_FIXED_BIT = 4;
    localparam int BOOST_CODE_MSB = 3;
    localparam logic [7:0] RESET_BOOST_CTRL = 8'h12;
    localparam logic [3:0] RESET_BOOST_CODE = 4'h2;

    // Detection and timer control fields.
    localparam int FORCE_DET_BIT = 7;
    localparam int TIMER_RESTART_BIT = 0;
    localparam logic [7:0] RESET_USB_DET = 8'h00;

    // Charge loop monitor fields.
    localparam int MON_ITERM_BIT = 7;
    localparam int MON_VBATMIN_BIT = 6;
    localparam int MON_LOWV_BIT = 5;
    localparam int MON_SHORT_BIT = 4;
    localparam int MON_FLOAT_BIT = 3;
    localparam int MON_INPUT_LOOP_BIT = 2;
    localparam int MON_CHARGE_LOOP_BIT = 1;
    localparam int MON_CV_BIT = 0;
    localparam logic [7:0] RESET_LOOP_MON = 8'h86;

    // Power path monitor fields.
    localparam int PATH_FIXED_BIT = 7;
    localparam int PATH_MID_BIT = 6;

    // Boost voltage scale: base in millivolts, step of 80/3 mV per code.
    localparam logic [12:0] BOOST_BASE_MV = 13'h1353;
    localparam logic [11:0] BOOST_STEP_NUM = 12'h050;
    localparam logic [11:0] BOOST_STEP_DEN = 12'h003;
    localparam logic [12:0] RESET_BOOST_TARGET_MV = 13'h1388;

    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    typedef enum logic [1:0] {
        MODE_FAST,
        MODE_PRE,
        MODE_BOOST,
        MODE_HZ
    } charge_mode_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic ibat_above_iterm;
        logic supply_present;
        logic vbat_above_min;
        logic vbat_above_lowv;
        logic vsys_above_batmin;
        logic vbat_above_boost_lv;
        logic vbat_above_short;
        logic vsys_above_boost_uvlo;
        logic vbat_at_float;
        logic termination_enable;
        logic input_loop_limiting;
        logic charge_loop_limiting;
        logic voltage_loop_active;
        logic mid_rail_above_battery;
    } analog_status_t;

    typedef struct packed {
        logic output_path_connect;
        logic boost_enable;
        logic [3:0] boost_voltage_code;
    } boost_ctrl_t;

endpackage

// [hdl/boost_ctrl_reg.sv]
// Boost converter control register with fault and enable driven clearing.
`timescale 1ns/1ns
module boost_ctrl_reg
    import charger_regs_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    // Register write and fault.
    input wire logic wr_en_in,
    input wire logic [7:0] wdata_in,
    input wire logic boost_fault_in,
    // Register contents.
    output boost_ctrl_t ctrl_out,
    output logic [7:0] rdata_out
);

    boost_ctrl_t state_q;
    boost_ctrl_t state_d;

    always_comb begin
        state_d = state_q;
        if (wr_en_in) begin
            state_d.output_path_connect = wdata_in[BOOST_CONNECT_BIT];
            state_d.boost_enable = wdata_in[BOOST_ENABLE_BIT]; // [RULE3]
            state_d.boost_voltage_code = wdata_in[BOOST_CODE_MSB:0]; // [RULE4]
        end
        // A fault while boost is enabled outranks a host write so boost cannot be re-armed in the fault cycle.
        if (boost_fault_in && state_q.boost_enable) begin
            state_d.boost_enable = 1'b0; // [RULE17]
        end
        if (!state_d.boost_enable) begin
            state_d.output_path_connect = 1'b0; // [RULE2]
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q.output_path_connect <= RESET_BOOST_CTRL[BOOST_CONNECT_BIT];
            state_q.boost_enable <= RESET_BOOST_CTRL[BOOST_ENABLE_BIT]; // [RULE3]
            state_q.boost_voltage_code <= RESET_BOOST_CODE; // [RULE4]
        end else begin
            state_q <= state_d;
        end
    end

    assign ctrl_out = state_q;

    always_comb begin
        rdata_out = 8'h00;
        rdata_out[BOOST_CONNECT_BIT] = state_q.output_path_connect;
        rdata_out[BOOST_ENABLE_BIT] = state_q.boost_enable;
        rdata_out[BOOST_FIXED_BIT] = RESET_BOOST_CTRL[BOOST_FIXED_BIT];
        rdata_out[BOOST_CODE_MSB:0] = state_q.boost_voltage_code;
    end

endmodule

// [hdl/status_flag_encoder.sv]
// Encodes live comparator and loop flags into the two monitor bytes.
`timescale 1ns/1ns
module status_flag_encoder
    import charger_regs_pkg::*;
(
    // Live analog state.
    input analog_status_t status_in,
    input charge_mode_t mode_in,
    // Monitor bytes.
    output logic [7:0] loop_mon_out,
    output logic [7:0] path_mon_out
);

    always_comb begin
        loop_mon_out = 8'h00;
        loop_mon_out[MON_ITERM_BIT] = status_in.ibat_above_iterm
            || !status_in.supply_present; // [RULE9]
        loop_mon_out[MON_VBATMIN_BIT] = status_in.vbat_above_min; // [RULE10]
        case (mode_in)
            MODE_FAST: begin
                loop_mon_out[MON_LOWV_BIT] = status_in.vbat_above_lowv; // [RULE11]
                loop_mon_out[MON_SHORT_BIT] = status_in.vbat_above_short; // [RULE12]
            end
            MODE_PRE: begin
                loop_mon_out[MON_LOWV_BIT] = status_in.vsys_above_batmin; // [RULE11]
                loop_mon_out[MON_SHORT_BIT] = status_in.vbat_above_short; // [RULE12]
            end
            MODE_BOOST: begin
                loop_mon_out[MON_LOWV_BIT] = status_in.vbat_above_boost_lv; // [RULE11]
                loop_mon_out[MON_SHORT_BIT] = status_in.vsys_above_boost_uvlo; // [RULE12]
            end
            MODE_HZ: begin
                loop_mon_out[MON_LOWV_BIT] = 1'b0;
                loop_mon_out[MON_SHORT_BIT] = status_in.vbat_above_short; // [RULE12]
            end
            default: begin
                loop_mon_out[MON_LOWV_BIT] = 1'b0;
                loop_mon_out[MON_SHORT_BIT] = 1'b0;
            end
        endcase
        loop_mon_out[MON_FLOAT_BIT] = status_in.vbat_at_float
            && !status_in.termination_enable; // [RULE13]
        loop_mon_out[MON_INPUT_LOOP_BIT] = !status_in.input_loop_limiting; // [RULE14]
        loop_mon_out[MON_CHARGE_LOOP_BIT] = !status_in.charge_loop_limiting; // [RULE14]
        loop_mon_out[MON_CV_BIT] = status_in.voltage_loop_active
            && !status_in.input_loop_limiting
            && !status_in.charge_loop_limiting; // [RULE15]
        path_mon_out = 8'h00;
        path_mon_out[PATH_FIXED_BIT] = 1'b1;
        path_mon_out[PATH_MID_BIT] = status_in.mid_rail_above_battery; // [RULE16]
    end

endmodule

// [hdl/charger_boost_status_regs.sv]
// Boost control, detection and timer strobes, and monitor read-back on the serial register port.
`timescale 1ns/1ns

// Summary of operation
// [RULE1] With connect and boost enable set, the mid rail is linked to the USB supply.
// [RULE2] The connect bit clears itself whenever boost enable is zero.
// [RULE3] Bit 5 picks charge (0) or boost (1) operation; resets to zero.
// [RULE4] Four-bit code maps 4.947 V to 5.347 V linearly; resets to 5.000 V.
// [RULE5] Writing one to bit 7 of the detection register starts charger detection.
// [RULE6] Writing one to the restart bit resets the safety timer while it governs charging.
// [RULE7] The restart bit always reads back as zero.
// [RULE8] Host writes the restart bit right after changing the pre-charge timer setting.
// [RULE9] Termination flag reads one above termination current or with no supply.
// [RULE10] Battery minimum flag is one when battery is above the minimum threshold.
// [RULE11] Low-voltage flag compares different rails in fast charge, pre-charge and boost.
// [RULE12] Short flag checks battery in charge and high impedance, system rail in boost.
// [RULE13] Over-float flag reads one at float voltage with termination disabled.
// [RULE14] Input and charge loop flags read zero while that loop limits current.
// [RULE15] Voltage loop flag reads one when it rules and current loops released.
// [RULE16] Mid rail above battery flag is bit 6 of the power path monitor.
// [RULE17] A boost fault clears boost enable, returning to charge mode.
// [RULE18] Monitor registers ignore writes and return live state sampled at the read.
module charger_boost_status_regs
    import charger_regs_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    // Serial register port from the byte engine.
    input reg_req_t req_in,
    output logic [7:0] rdata_out,
    output logic rd_ack_out,
    // Live comparator, loop and mode state.
    input analog_status_t status_in,
    input charge_mode_t mode_in,
    input wire logic boost_fault_in,
    input wire logic safety_timer_active_in,
    // Controls to the power stage and charger sequencer.
    output logic boost_enable_out,
    output logic mid_rail_link_out,
    output logic [3:0] boost_voltage_code_out,
    output logic [12:0] boost_target_mv_out,
    output logic force_charger_detection_out,
    output logic detection_start_out,
    output logic safety_timer_restart_out
);

    typedef struct packed {
        logic [7:0] rdata;
        logic rd_ack;
        logic force_det;
        logic det_start;
        logic timer_restart;
        logic link;
        logic boost_en;
        logic [3:0] code;
        logic [12:0] target_mv;
    } top_state_t;

    top_state_t state_q;
    top_state_t state_d;

    boost_ctrl_t boost_ctrl;
    logic [7:0] boost_rdata;
    logic [7:0] loop_mon;
    logic [7:0] path_mon;
    logic boost_wr;
    logic det_wr;
    logic [11:0] step_scaled;
    logic [11:0] step_mv;

    function automatic logic addr_hit(input reg_req_t req, input logic [7:0] target);
        addr_hit = (req.addr == target);
    endfunction

    assign boost_wr = req_in.wr && addr_hit(req_in, ADDR_BOOST_CTRL);
    assign det_wr = req_in.wr && addr_hit(req_in, ADDR_USB_DET);

    boost_ctrl_reg u_boost_ctrl (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .wr_en_in(boost_wr),
        .wdata_in(req_in.wdata),
        .boost_fault_in(boost_fault_in),
        .ctrl_out(boost_ctrl),
        .rdata_out(boost_rdata)
    );

    status_flag_encoder u_flags (
        .status_in(status_in),
        .mode_in(mode_in),
        .loop_mon_out(loop_mon),
        .path_mon_out(path_mon)
    );

    // Floor of code times 80/3 reproduces every step of the voltage table exactly.
    assign step_scaled = {8'h00, boost_ctrl.boost_voltage_code} * BOOST_STEP_NUM;
    assign step_mv = step_scaled / BOOST_STEP_DEN;

    always_comb begin
        state_d = state_q;
        state_d.rd_ack = 1'b0;
        state_d.det_start = 1'b0;
        state_d.timer_restart = 1'b0;

        if (det_wr) begin
            state_d.force_det = req_in.wdata[FORCE_DET_BIT];
            state_d.det_start = req_in.wdata[FORCE_DET_BIT]; // [RULE5]
            // Restart is only meaningful while the safety timer governs charging.
            state_d.timer_restart = req_in.wdata[TIMER_RESTART_BIT]
                && safety_timer_active_in; // [RULE6]
        end

        // Writes to the monitor addresses fall through with no effect.
        if (req_in.rd) begin
            state_d.rd_ack = 1'b1;
            case (req_in.addr)
                ADDR_BOOST_CTRL: begin
                    state_d.rdata = boost_rdata;
                end
                ADDR_USB_DET: begin
                    state_d.rdata = 8'h00; // [RULE7]
                    state_d.rdata[FORCE_DET_BIT] = state_q.force_det;
                end
                ADDR_LOOP_MON: begin
                    state_d.rdata = loop_mon; // [RULE18]
                end
                ADDR_PATH_MON: begin
                    state_d.rdata = path_mon; // [RULE18]
                end
                default: begin
                    state_d.rdata = READ_UNMAPPED;
                end
            endcase
        end

        state_d.boost_en = boost_ctrl.boost_enable;
        state_d.link = boost_ctrl.output_path_connect && boost_ctrl.boost_enable; // [RULE1]
        state_d.code = boost_ctrl.boost_voltage_code;
        state_d.target_mv = BOOST_BASE_MV + {1'b0, step_mv}; // [RULE4]
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q.rdata <= 8'h00;
            state_q.rd_ack <= 1'b0;
            state_q.force_det <= RESET_USB_DET[FORCE_DET_BIT];
            state_q.det_start <= 1'b0;
            state_q.timer_restart <= 1'b0;
            state_q.link <= 1'b0;
            state_q.boost_en <= RESET_BOOST_CTRL[BOOST_ENABLE_BIT];
            state_q.code <= RESET_BOOST_CODE;
            state_q.target_mv <= RESET_BOOST_TARGET_MV; // [RULE4]
        end else begin
            state_q <= state_d;
        end
    end

    assign rdata_out = state_q.rdata;
    assign rd_ack_out = state_q.rd_ack;
    assign boost_enable_out = state_q.boost_en;
    assign mid_rail_link_out = state_q.link;
    assign boost_voltage_code_out = state_q.code;
    assign boost_target_mv_out = state_q.target_mv;
    assign force_charger_detection_out = state_q.force_det;
    assign detection_start_out = state_q.det_start;
    assign safety_timer_restart_out = state_q.timer_restart;

endmodule

// [test/reg_host_model.sv]
// Host model issuing reads and writes on the serial register port.
`timescale 1ns/1ns
module reg_host_model
    import charger_regs_pkg::*;
(
    // Clock.
    input wire logic ref_clk_in,
    // Register port.
    output reg_req_t req_out,
    input wire logic [7:0] rdata_in,
    input wire logic rd_ack_in
);
    initial req_out = '0;
    // Released address and data are inverted so stale values never pass for valid ones.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk_in);
        req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge ref_clk_in);
        req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5a};
        @(posedge ref_clk_in);
        req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'ha5};
        ok = 1'b0;
        for (int n = 0; n < 4 && !ok; n++) begin
            @(posedge ref_clk_in);
            ok = (rd_ack_in === 1'b1);
        end
        d = rdata_in;
    endtask
endmodule

// [test/charger_boost_status_regs_monitor.sv]
// Concurrent checks on the boost control and monitor register ports.
`timescale 1ns/1ns
module charger_boost_status_regs_monitor
    import charger_regs_pkg::*;
(
    // Clock, reset and inputs.
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input reg_req_t req_in,
    input analog_status_t status_in,
    input wire logic boost_fault_in,
    input wire logic safety_timer_active_in,
    // Outputs.
    input wire logic [7:0] rdata_out,
    input wire logic rd_ack_out,
    input wire logic boost_enable_out,
    input wire logic mid_rail_link_out,
    input wire logic [3:0] boost_voltage_code_out,
    input wire logic [12:0] boost_target_mv_out,
    input wire logic detection_start_out,
    input wire logic safety_timer_restart_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    sequence rd_s(logic [7:0] a);
        req_in.rd && req_in.addr == a;
    endsequence
    sequence det_wr_s;
        req_in.wr && req_in.addr == ADDR_USB_DET;
    endsequence
    sequence boost_wr_s;
        req_in.wr && req_in.addr == ADDR_BOOST_CTRL;
    endsequence
    AST_RD_ACK: assert property (req_in.rd |=> rd_ack_out)
        else $error("read not acknowledged");
    AST_ACK_CAUSE: assert property (rd_ack_out |-> $past(req_in.rd))
        else $error("acknowledge without read");
    AST_LOOP_HI: assert property (rd_s(ADDR_LOOP_MON) |=> rdata_out[7:6] ==
        $past({status_in.ibat_above_iterm | !status_in.supply_present, status_in.vbat_above_min}))
        else $error("loop monitor upper flags wrong");
    AST_LOOP_LO: assert property (rd_s(ADDR_LOOP_MON) |=> rdata_out[2:0] == $past({
        !status_in.input_loop_limiting, !status_in.charge_loop_limiting,
        status_in.voltage_loop_active & !status_in.input_loop_limiting &
        !status_in.charge_loop_limiting}))
        else $error("loop monitor lower flags wrong");
    AST_PATH: assert property (rd_s(ADDR_PATH_MON) |=> rdata_out[7:6] ==
        {1'b1, $past(status_in.mid_rail_above_battery)})
        else $error("path monitor wrong");
    AST_RESTART_RD: assert property (rd_s(ADDR_USB_DET) |=> rdata_out[6:0] == 7'h00)
        else $error("restart bit read back");
    AST_DET: assert property (det_wr_s ##0 req_in.wdata[7] |=> detection_start_out)
        else $error("detection not started");
    AST_RESTART: assert property (det_wr_s ##0 safety_timer_active_in |=>
        safety_timer_restart_out == $past(req_in.wdata[0]))
        else $error("timer restart wrong");
    AST_LINK: assert property (mid_rail_link_out |-> boost_enable_out)
        else $error("link without boost");
    AST_LINK_SET: assert property (boost_wr_s ##0 (req_in.wdata[6:5] == 2'b11 &&
        !boost_fault_in) |-> ##2 mid_rail_link_out)
        else $error("link not made");
    AST_CONNECT_CLR: assert property (boost_wr_s ##0 !req_in.wdata[5] |->
        ##2 !mid_rail_link_out)
        else $error("link kept without boost");
    // The enable output lags the register by one cycle, so it shows the enable seen by the fault.
    AST_FAULT: assert property (boost_fault_in ##1 boost_enable_out |=> !boost_enable_out)
        else $error("fault left boost on");
    AST_TARGET: assert property (boost_target_mv_out ==
        BOOST_BASE_MV + 13'(32'(boost_voltage_code_out) * 80 / 3))
        else $error("boost target wrong");
endmodule
bind charger_boost_status_regs charger_boost_status_regs_monitor mon_u (.ref_clk_in, .resetn_in,
    .req_in, .status_in, .boost_fault_in, .safety_timer_active_in, .rdata_out, .rd_ack_out,
    .boost_enable_out, .mid_rail_link_out, .boost_voltage_code_out, .boost_target_mv_out,
    .detection_start_out, .safety_timer_restart_out);

// [test/charger_boost_status_regs_tb.sv]
// Self-checking bench for the boost control and monitor register slice.
`timescale 1ns/1ns
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("mismatch %s expected %h seen %h", what, exp, got); end end
module charger_boost_status_regs_tb
    import charger_regs_pkg::*;
;
    logic ref_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    reg_req_t req_in;
    analog_status_t status_in = '0;
    charge_mode_t mode_in = MODE_FAST;
    logic boost_fault_in = 1'b0;
    logic safety_timer_active_in = 1'b0;
    logic [7:0] rdata_out, rd_v;
    logic [3:0] boost_voltage_code_out;
    logic [12:0] boost_target_mv_out;
    logic rd_ack_out, boost_enable_out, mid_rail_link_out, ok_v;
    logic force_charger_detection_out, detection_start_out, safety_timer_restart_out;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    always #2 ref_clk_in = ~ref_clk_in;
    reg_host_model host_u (.ref_clk_in, .req_out(req_in), .rdata_in(rdata_out),
        .rd_ack_in(rd_ack_out));
    charger_boost_status_regs dut_u (.ref_clk_in, .resetn_in, .req_in, .rdata_out, .rd_ack_out,
        .status_in, .mode_in, .boost_fault_in, .safety_timer_active_in, .boost_enable_out,
        .mid_rail_link_out, .boost_voltage_code_out, .boost_target_mv_out,
        .force_charger_detection_out, .detection_start_out, .safety_timer_restart_out);
    function automatic logic [7:0] exp_loop(analog_status_t s, charge_mode_t m);
        logic b5;
        logic b4;
        b5 = (m == MODE_FAST) ? s.vbat_above_lowv : (m == MODE_PRE) ? s.vsys_above_batmin :
            (m == MODE_BOOST) ? s.vbat_above_boost_lv : 1'b0;
        b4 = (m == MODE_BOOST) ? s.vsys_above_boost_uvlo : s.vbat_above_short;
        return {s.ibat_above_iterm | ~s.supply_present, s.vbat_above_min, b5, b4,
            s.vbat_at_float & ~s.termination_enable, ~s.input_loop_limiting,
            ~s.charge_loop_limiting,
            s.voltage_loop_active & ~s.input_loop_limiting & ~s.charge_loop_limiting};
    endfunction
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        host_u.rd(a, rd_v, ok_v);
        `CHK({what, " ack"}, 1'b1, ok_v)
        `CHK(what, exp, rd_v)
    endtask
    task automatic t_reset();
        `CHK("code", 4'h2, boost_voltage_code_out)
        `CHK("target", 13'h1388, boost_target_mv_out)
        rd_chk("boost reg", ADDR_BOOST_CTRL, 8'h12);
        rd_chk("usb reg", ADDR_USB_DET, 8'h00);
        rd_chk("unmapped", 8'h33, 8'h00);
    endtask
    task automatic t_boost();
        host_u.wr(ADDR_BOOST_CTRL, 8'h62);
        rd_chk("enable", ADDR_BOOST_CTRL, 8'h72);
        `CHK("link", 1'b1, mid_rail_link_out)
        host_u.wr(ADDR_BOOST_CTRL, 8'h4f);
        rd_chk("connect", ADDR_BOOST_CTRL, 8'h1f);
        `CHK("link off", 1'b0, mid_rail_link_out)
        for (int c = 0; c < 16; c++) begin
            host_u.wr(ADDR_BOOST_CTRL, 8'(c));
            repeat (2) @(posedge ref_clk_in);
            `CHK("code", 4'(c), boost_voltage_code_out)
            `CHK("mv", 13'h1353 + 13'(c * 80 / 3), boost_target_mv_out)
        end
        host_u.wr(ADDR_BOOST_CTRL, 8'h6f);
        @(posedge ref_clk_in);
        boost_fault_in <= 1'b1;
        @(posedge ref_clk_in);
        boost_fault_in <= 1'b0;
        rd_chk("fault", ADDR_BOOST_CTRL, 8'h1f);
        `CHK("enable off", 1'b0, boost_enable_out)
        host_u.wr(ADDR_BOOST_CTRL, 8'h62);
        fork
            host_u.wr(ADDR_BOOST_CTRL, 8'h63);
            begin
                @(posedge ref_clk_in);
                boost_fault_in <= 1'b1;
                @(posedge ref_clk_in);
                boost_fault_in <= 1'b0;
            end
        join
        rd_chk("fault wins", ADDR_BOOST_CTRL, 8'h13);
    endtask
    task automatic t_rerun();
        host_u.wr(ADDR_BOOST_CTRL, 8'h62);
        repeat (2) @(posedge ref_clk_in);
        `CHK("pre reset boost", 1'b1, boost_enable_out)
        resetn_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        @(posedge ref_clk_in);
        `CHK("rerun code", 4'h2, boost_voltage_code_out)
        `CHK("rerun target", 13'h1388, boost_target_mv_out)
        `CHK("rerun boost", 1'b0, boost_enable_out)
        rd_chk("rerun usb", ADDR_USB_DET, 8'h00);
    endtask
    task automatic t_usb();
        safety_timer_active_in <= 1'b1;
        host_u.wr(ADDR_USB_DET, 8'h81);
        @(posedge ref_clk_in);
        `CHK("det start", 1'b1, detection_start_out)
        `CHK("restart", 1'b1, safety_timer_restart_out)
        @(posedge ref_clk_in);
        `CHK("det single", 1'b0, detection_start_out)
        rd_chk("restart rd", ADDR_USB_DET, 8'h80);
        `CHK("force", 1'b1, force_charger_detection_out)
        safety_timer_active_in <= 1'b0;
        host_u.wr(ADDR_USB_DET, 8'h01);
        @(posedge ref_clk_in);
        `CHK("restart idle", 1'b0, safety_timer_restart_out)
    endtask
    task automatic t_mon();
        analog_status_t pat[4] = '{14'h3fff, 14'h0000, 14'h2aaa, 14'h1555};
        for (int p = 0; p < 4; p++) begin
            for (int m = 0; m < 4; m++) begin
                status_in <= pat[p];
                mode_in <= charge_mode_t'(m);
                host_u.wr(ADDR_LOOP_MON, 8'hff);
                rd_chk("loop mon", ADDR_LOOP_MON, exp_loop(pat[p], charge_mode_t'(m)));
            end
            host_u.wr(ADDR_PATH_MON, 8'h00);
            rd_chk("path mon", ADDR_PATH_MON, {2'h2 | 2'(pat[p].mid_rail_above_battery), 6'h00});
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Ceiling well above the few hundred cycles the scenarios need.
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (20) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        @(posedge ref_clk_in);
        t_reset();
        t_boost();
        t_usb();
        t_rerun();
        t_mon();
        end_of_test();
    end
endmodule
